// ---- design/psa_pkg.sv ----
// Package of constants for the product shift and accumulate datapath slice
// Summary of operation
// - Product subtract: accumulator minus shifted product
// - Product passes shifter before subtract
// - Store high half of shifted product
// - Store low half of shifted product
// - Store sixteen-bit immediate to memory word
// - Immediate store bypasses ALU, accumulator unchanged
// - Set shift mode from two-bit immediate
// - Mode 00 passes product unshifted
// - Mode 01 shifts left one, zero fill
// - Mode 10 shifts left four, zero fill
// - Mode 11 arithmetic right six, drop lsbs
// - Square accumulate adds shifted old product first
// - Then load operand, square into product
package psa_pkg;
  localparam int PSA_ACC_W = 32;
  localparam int PSA_DATA_W = 16;
  localparam int PSA_ADDR_W = 16;
  localparam int PSA_PM_W = 2;
  // Shift amounts of the product output shifter
  localparam int PSA_SHL_ONE = 1;
  localparam int PSA_SHL_FOUR = 4;
  localparam int PSA_SHR_SIX = 6;
  // Shift mode encodings
  localparam logic [1:0] PSA_PM_NONE = 2'h0;
  localparam logic [1:0] PSA_PM_L1 = 2'h1;
  localparam logic [1:0] PSA_PM_L4 = 2'h2;
  localparam logic [1:0] PSA_PM_R6 = 2'h3;
  localparam logic [1:0] PSA_PM_RESET = 2'h0;
  // Operation codes from the sequencer
  localparam logic [2:0] PSA_OP_NOP = 3'h0;
  localparam logic [2:0] PSA_OP_SUB = 3'h1;
  localparam logic [2:0] PSA_OP_STH = 3'h2;
  localparam logic [2:0] PSA_OP_STL = 3'h3;
  localparam logic [2:0] PSA_OP_STIMM = 3'h4;
  localparam logic [2:0] PSA_OP_SETPM = 3'h5;
  localparam logic [2:0] PSA_OP_SQUARE_ACCUMULATE_OP = 3'h6;
  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    PSA_ST_IDLE = 2'b01,
    PSA_ST_READ = 2'b10
  } psa_state_e;
endpackage

// ---- design/psa_shifter.sv ----
// Product output shifter selected by the shift-mode field
`timescale 1ns/100ps
module psa_shifter
  import psa_pkg::*;
#(
  parameter int W = 32
) (
  // Control and data
  input wire logic [1:0] mode_i,
  input wire logic [W-1:0] prod_i,
  output logic [W-1:0] shifted_o
);
  // Select shift per mode
  always_comb begin
    case (mode_i)
      PSA_PM_NONE: shifted_o = prod_i;
      PSA_PM_L1: shifted_o = prod_i << PSA_SHL_ONE;
      PSA_PM_L4: shifted_o = prod_i << PSA_SHL_FOUR;
      PSA_PM_R6: shifted_o = $signed(prod_i) >>> PSA_SHR_SIX;
      default: shifted_o = prod_i;
    endcase
  end
endmodule

// ---- design/psa_core.sv ----
// Product register handling: shift, accumulate, stores and square
`timescale 1ns/100ps
module psa_core
  import psa_pkg::*;
#(
  parameter int ACC_W = PSA_ACC_W,
  parameter int DATA_W = PSA_DATA_W,
  parameter int ADDR_W = PSA_ADDR_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Sequencer command
  input wire logic op_valid_i,
  input wire logic [2:0] op_code_i,
  input wire logic [ADDR_W-1:0] op_addr_i,
  input wire logic [DATA_W-1:0] op_imm_i,
  output logic op_busy_o,
  // Accumulator and product load from the rest of the core
  input wire logic acc_load_i,
  input wire logic [ACC_W-1:0] acc_load_data_i,
  input wire logic prod_load_i,
  input wire logic [ACC_W-1:0] prod_load_data_i,
  // Data memory port
  output logic mem_we_o,
  output logic mem_re_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [DATA_W-1:0] mem_wdata_o,
  input wire logic [DATA_W-1:0] mem_rdata_i,
  // Datapath state
  output logic [ACC_W-1:0] acc_o,
  output logic [ACC_W-1:0] prod_o,
  output logic [DATA_W-1:0] treg_o,
  output logic [PSA_PM_W-1:0] product_shift_mode_o
);
  // Each group of state has one next-value process and one register process
  // Accumulator group
  logic [ACC_W-1:0] acc_reg; // Running accumulator
  logic [ACC_W-1:0] acc_next; // Accumulator value for the next edge
  // Product group
  logic [ACC_W-1:0] prod_reg; // Product register, raw multiplier result
  logic [ACC_W-1:0] prod_next; // Product value for the next edge
  // Multiplier operand group
  logic [DATA_W-1:0] treg_reg; // Operand word of the last square
  logic [DATA_W-1:0] treg_next; // Operand value for the next edge
  // Shift mode group
  logic [PSA_PM_W-1:0] pm_reg; // Product shift mode field of status word one
  logic [PSA_PM_W-1:0] pm_next; // Shift mode for the next edge
  // Sequencer group
  psa_state_e state_reg; // Idle or waiting for the square operand
  psa_state_e state_next; // Sequencer state for the next edge
  logic busy_reg; // Flop behind the busy output, high in the wait state
  logic busy_next; // Busy value for the next edge
  // Memory port group
  logic we_reg; // Write strobe, one cycle per store
  logic we_next; // Write strobe for the next edge
  logic re_reg; // Read strobe, one cycle per square
  logic re_next; // Read strobe for the next edge
  logic [ADDR_W-1:0] addr_reg; // Word address, held after the access
  logic [ADDR_W-1:0] addr_next; // Address for the next edge
  logic [DATA_W-1:0] wdata_reg; // Write data, held after the access
  logic [DATA_W-1:0] wdata_next; // Write data for the next edge
  // Shifter output
  logic [ACC_W-1:0] prod_shifted; // Product as the current mode presents it
  // Signed square of the loaded word
  logic signed [2*DATA_W-1:0] square; // Full square of the read word
  // Command decode
  logic op_take; // A command is accepted on this edge
  logic do_sub; // Product subtract accepted
  logic do_sth; // Store high half accepted
  logic do_stl; // Store low half accepted
  logic do_stimm; // Immediate store accepted
  logic do_setpm; // Set shift mode accepted
  logic do_square_accumulate_op; // Square accumulate accepted
  logic do_store; // Any of the three stores accepted
  logic sq_load; // Square operand arrives on this edge
  // Immediate store data from the bit-logic path
  logic [DATA_W-1:0] parallel_bit_logic_unit_data; // Word written by the immediate store

  // Shift the product by the current mode; the raw product is never altered
  psa_shifter #(
    .W(ACC_W)
  ) psa_shifter_inst (
    .mode_i(pm_reg),
    .prod_i(prod_reg),
    .shifted_o(prod_shifted)
  );

  // Signed square of the read word; both operands sign extended to full width
  assign square = $signed(mem_rdata_i) * $signed(mem_rdata_i);

  // Decode the command; nothing is taken while the square waits for its operand
  always_comb begin
    op_take = op_valid_i && (state_reg == PSA_ST_IDLE);
    do_sub = 1'b0;
    do_sth = 1'b0;
    do_stl = 1'b0;
    do_stimm = 1'b0;
    do_setpm = 1'b0;
    do_square_accumulate_op = 1'b0;
    if (op_take) begin
      case (op_code_i)
        PSA_OP_SUB: begin
          // Product subtract
          do_sub = 1'b1;
        end
        PSA_OP_STH: begin
          // Store high half
          do_sth = 1'b1;
        end
        PSA_OP_STL: begin
          // Store low half
          do_stl = 1'b1;
        end
        PSA_OP_STIMM: begin
          // Immediate store
          do_stimm = 1'b1;
        end
        PSA_OP_SETPM: begin
          // Set shift mode
          do_setpm = 1'b1;
        end
        PSA_OP_SQUARE_ACCUMULATE_OP: begin
          // Square accumulate
          do_square_accumulate_op = 1'b1;
        end
        default: begin
          // No operation and spare codes do nothing
          do_sub = 1'b0;
        end
      endcase
    end
    do_store = do_sth || do_stl || do_stimm;
    sq_load = (state_reg == PSA_ST_READ);
  end

  // Immediate store passes through the bit-logic path, apart from the adder
  assign parallel_bit_logic_unit_data = op_imm_i;

  // Sequencer next state: one wait cycle after each square accumulate
  always_comb begin
    state_next = state_reg;
    busy_next = 1'b0;
    case (state_reg)
      PSA_ST_IDLE: begin
        // Leave idle only for a square accumulate
        if (do_square_accumulate_op) begin
          state_next = PSA_ST_READ;
          busy_next = 1'b1;
        end
      end
      PSA_ST_READ: begin
        // Operand arrives now; back to idle
        state_next = PSA_ST_IDLE;
      end
      default: begin
        // Illegal code recovers to idle
        state_next = PSA_ST_IDLE;
      end
    endcase
  end

  // Register the sequencer
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_reg <= PSA_ST_IDLE;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg <= busy_next;
    end
  end

  // Accumulator next value; a command beats a load from the rest of the core
  always_comb begin
    acc_next = acc_reg;
    if (acc_load_i) begin
      // Load from the rest of the core
      acc_next = acc_load_data_i;
    end
    if (do_sub) begin
      // Subtract the shifted product
      acc_next = acc_reg - prod_shifted;
    end else if (do_square_accumulate_op) begin
      // Add the shifted old product before it is replaced
      acc_next = acc_reg + prod_shifted;
    end
  end

  // Register the accumulator
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // Product next value; the square result replaces any load in the same cycle
  always_comb begin
    prod_next = prod_reg;
    if (prod_load_i) begin
      // Load from the multiplier
      prod_next = prod_load_data_i;
    end
    if (sq_load) begin
      // Square of the operand word just read
      prod_next = ACC_W'(square);
    end
  end

  // Register the product
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      prod_reg <= '0;
    end else begin
      prod_reg <= prod_next;
    end
  end

  // Operand register takes the word that the square uses
  always_comb begin
    treg_next = treg_reg;
    if (sq_load) begin
      // Same word as the squarer sees
      treg_next = mem_rdata_i;
    end
  end

  // Register the operand
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      treg_reg <= '0;
    end else begin
      treg_reg <= treg_next;
    end
  end

  // Shift mode takes the two low immediate bits
  always_comb begin
    pm_next = pm_reg;
    if (do_setpm) begin
      // Upper immediate bits are ignored
      pm_next = op_imm_i[PSA_PM_W-1:0];
    end
  end

  // Register the shift mode
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pm_reg <= PSA_PM_RESET;
    end else begin
      pm_reg <= pm_next;
    end
  end

  // Memory port next values; strobes last one cycle, address and data hold
  always_comb begin
    we_next = 1'b0;
    re_next = 1'b0;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    if (do_store || do_square_accumulate_op) begin
      // Every memory command carries its address
      addr_next = op_addr_i;
    end
    if (do_sth) begin
      // Upper half of the shifted product
      we_next = 1'b1;
      wdata_next = prod_shifted[ACC_W-1 -: DATA_W];
    end else if (do_stl) begin
      // Lower half of the shifted product
      we_next = 1'b1;
      wdata_next = prod_shifted[DATA_W-1:0];
    end else if (do_stimm) begin
      // Whole immediate word; accumulator left alone
      we_next = 1'b1;
      wdata_next = parallel_bit_logic_unit_data;
    end else if (do_square_accumulate_op) begin
      // Fetch the operand word for the square
      re_next = 1'b1;
    end
  end

  // Register the memory port
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      we_reg <= 1'b0;
      re_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      we_reg <= we_next;
      re_reg <= re_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
    end
  end

  // Outputs straight from flip-flops
  assign acc_o = acc_reg;
  assign prod_o = prod_reg;
  assign treg_o = treg_reg;
  assign product_shift_mode_o = pm_reg;
  // Memory strobes, address and data
  assign mem_we_o = we_reg;
  assign mem_re_o = re_reg;
  assign mem_addr_o = addr_reg;
  assign mem_wdata_o = wdata_reg;
  // Busy has its own flop so no decode sits on the output
  assign op_busy_o = busy_reg;
endmodule

// ---- verification/psa_core_chk.sv ----
// Port assertions for the product shift core
`timescale 1ns/100ps
module psa_core_chk import psa_pkg::*; (
  // Watched ports
  input wire logic clk_i, nrst_i, op_valid_i, op_busy_o, mem_we_o, mem_re_o, acc_load_i,
  input wire logic [2:0] op_code_i,
  input wire logic [15:0] op_addr_i, op_imm_i, mem_addr_o, mem_wdata_o, mem_rdata_i, treg_o,
  input wire logic [31:0] acc_o, prod_o,
  input wire logic [1:0] product_shift_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic signed [31:0] s6; // Product shifted right six, sign kept
  logic signed [31:0] rd; // Read word as signed
  logic [31:0] sp; // Expected shifter output
  logic go; // Command taken
  assign s6 = $signed(prod_o) >>> 6;
  assign rd = $signed(mem_rdata_i);
  assign sp = product_shift_mode_o[1] ? (product_shift_mode_o[0] ? s6 : prod_o << 4)
    : (product_shift_mode_o[0] ? prod_o << 1 : prod_o);
  assign go = op_valid_i && !op_busy_o;
  AST_SUB: assert property (go && op_code_i == PSA_OP_SUB |=>
    acc_o == $past(acc_o) - $past(sp)) else $error("bad subtract");
  AST_STH: assert property (go && op_code_i == PSA_OP_STH |=> mem_we_o &&
    mem_wdata_o == $past(sp[31:16]) && mem_addr_o == $past(op_addr_i)) else $error("bad high");
  AST_STL: assert property (go && op_code_i == PSA_OP_STL |=> mem_we_o &&
    mem_wdata_o == $past(sp[15:0])) else $error("bad low");
  AST_IMM: assert property (go && op_code_i == PSA_OP_STIMM && !acc_load_i |=>
    mem_wdata_o == $past(op_imm_i) && acc_o == $past(acc_o)) else $error("bad immediate");
  AST_PM: assert property (go && op_code_i == PSA_OP_SETPM |=>
    product_shift_mode_o == $past(op_imm_i[1:0])) else $error("bad mode");
  AST_SQA: assert property (go && op_code_i == PSA_OP_SQUARE_ACCUMULATE_OP |=>
    mem_re_o && acc_o == $past(acc_o) + $past(sp)) else $error("bad accumulate");
  AST_SQP: assert property (mem_re_o |=> !op_busy_o &&
    prod_o == $past(rd * rd) && treg_o == $past(mem_rdata_i)) else $error("bad square");
  AST_RST: assert property ($rose(nrst_i) |->
    product_shift_mode_o == PSA_PM_RESET && acc_o == 32'h0) else $error("bad reset");
  AST_DROP: assert property (op_valid_i && op_busy_o && !acc_load_i |=>
    acc_o == $past(acc_o) && !mem_we_o) else $error("command taken while busy");
  cover property (op_valid_i && op_busy_o);
  cover property (go && op_code_i == PSA_OP_SQUARE_ACCUMULATE_OP);
  cover property (go && op_code_i == PSA_OP_SUB);
  cover property (mem_we_o && product_shift_mode_o == PSA_PM_R6);
endmodule
bind psa_core psa_core_chk psa_core_chk_inst (.*);

// ---- verification/psa_mem_model.sv ----
// Data memory model at the core's memory port
`timescale 1ns/100ps
module psa_mem_model (
  // Memory port
  input wire logic clk_i, we_i, re_i,
  input wire logic [15:0] addr_i, wdata_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [256]; // Word store
  // Word only while read, changing junk otherwise
  assign rdata_o = re_i ? mem[addr_i[7:0]] : ~addr_i;
  // Write on the edge that sees the strobe
  always @(posedge clk_i) if (we_i) mem[addr_i[7:0]] <= wdata_i;
endmodule

// ---- verification/test_psa_core.sv ----
// Bench for the product shift core
`timescale 1ns/100ps
module test_psa_core import psa_pkg::*; ;
  logic clk_i = 0, nrst_i = 0, op_valid_i = 0, acc_load_i = 0, prod_load_i = 0;
  logic [2:0] op_code_i = 3'h0;
  logic [15:0] op_addr_i = 16'h0, op_imm_i = 16'h0, mem_rdata_i, mem_addr_o, mem_wdata_o, treg_o;
  logic [31:0] acc_load_data_i = 32'h0, prod_load_data_i = 32'h0, acc_o, prod_o;
  logic op_busy_o, mem_we_o, mem_re_o;
  logic [1:0] product_shift_mode_o;
  int n_errors = 0, cmp_count = 0;
  // Product 80001234 through modes 00 to 11
  localparam logic [31:0] SH [4] = '{32'h80001234, 32'h2468, 32'h12340, 32'hfe000048};
  always #20 clk_i = ~clk_i;
  psa_core psa_core_inst (.*);
  psa_mem_model psa_mem_model_inst (.clk_i, .we_i(mem_we_o), .re_i(mem_re_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: %h not %h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [15:0] mm(input int a);
    return psa_mem_model_inst.mem[a];
  endfunction
  // One command, then an idle cycle
  task automatic op(input logic [2:0] c, input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_i);
    {op_code_i, op_addr_i, op_imm_i, op_valid_i} = {c, a, d, 1'h1};
    @(negedge clk_i);
    op_valid_i = 1'h0;
  endtask
  task automatic ld(input logic [31:0] a, input logic [31:0] p);
    @(negedge clk_i);
    {acc_load_i, prod_load_i, acc_load_data_i, prod_load_data_i} = {2'h3, a, p};
    @(negedge clk_i);
    {acc_load_i, prod_load_i} = 2'h0;
  endtask
  // Every shift mode, both halves stored
  task automatic modes();
    ld(32'h0, SH[0]);
    for (int m = 0; m < 4; m++) begin
      op(PSA_OP_SETPM, 16'h0, 16'(m));
      chk(32'(product_shift_mode_o), 32'(m));
      op(PSA_OP_STH, 16'(2 * m), 16'h0);
      op(PSA_OP_STL, 16'(2 * m + 1), 16'h0);
      @(negedge clk_i);
      chk({mm(2 * m), mm(2 * m + 1)}, SH[m]);
    end
  endtask
  // Subtract in mode 11, then immediate store
  task automatic subimm();
    ld(32'h10, SH[0]);
    op(PSA_OP_SUB, 16'h0, 16'h0);
    chk(acc_o, 32'h01ffffc8);
    op(PSA_OP_STIMM, 16'h14, 16'hfffd);
    @(negedge clk_i);
    chk(32'(mm(20)), 32'hfffd);
    chk(acc_o, 32'h01ffffc8);
  endtask
  // Square a negative word after adding old product; a subtract while busy is dropped
  task automatic square();
    op(PSA_OP_SETPM, 16'h0, 16'h1);
    ld(32'h0, 32'h5);
    @(negedge clk_i);
    {op_code_i, op_addr_i, op_imm_i, op_valid_i} = {PSA_OP_SQUARE_ACCUMULATE_OP, 16'h14, 16'h0, 1'h1};
    @(negedge clk_i);
    op_code_i = PSA_OP_SUB;
    chk(acc_o, 32'ha);
    chk({31'h0, op_busy_o}, 32'h1);
    chk({15'h0, mem_re_o, mem_addr_o}, 32'h10014);
    @(negedge clk_i);
    op_valid_i = 1'h0;
    chk(acc_o, 32'ha);
    chk({31'h0, op_busy_o}, 32'h0);
    chk(prod_o, 32'h9);
    chk(32'(treg_o), 32'hfffd);
  endtask
  // Reset in mid-run returns mode and accumulator to zero
  task automatic rerun();
    @(negedge clk_i);
    nrst_i = 1'h0;
    @(negedge clk_i);
    chk(32'(product_shift_mode_o), 32'(PSA_PM_RESET));
    chk(acc_o, 32'h0);
    nrst_i = 1'h1;
    @(negedge clk_i);
  endtask
  initial begin
    repeat (4) @(negedge clk_i);
    chk(acc_o, 32'h0);
    chk(32'(product_shift_mode_o), 32'(PSA_PM_RESET));
    nrst_i = 1'h1;
    modes();
    subimm();
    square();
    rerun();
    print_verdict();
  end
  // Hang guard
  initial begin
    #20000;
    n_errors++;
    print_verdict();
  end
endmodule
